// *** core/acl_chan.sv ***
// acl_chan: one channel's effective gain and mute, combinational
// assumes: inputs come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module acl_chan (
  input  wire logic [2:0]      input_gain_code,
  input  wire logic [4:0]      volume_code,
  input  wire logic            global_mute,
  input  wire logic            headphone,
  output var  acl_pkg::acl_chan_s result
);

  logic signed [7:0] in_db;
  logic signed [7:0] vol_db;

  // input gain runs -15 dB to +6 dB in 3 dB steps
  assign in_db = 8'(signed'({5'h00, input_gain_code}) * 3 - 15);

  // volume: code 1 is -42 dB, 2 dB a step, capped at +12 dB for 111xx
  always_comb
  begin
    if (volume_code[4:2] == 3'b111)
      vol_db = 8'sd12;
    else
      vol_db = 8'(signed'({3'h0, volume_code}) * 2 - 44);
  end

  // mute leaves the stored code alone so the old volume comes back
  always_comb
  begin
    result.muted = (volume_code == acl_pkg::VOL_MUTE_CODE) || global_mute;
    if (headphone)
      result.gain_db = 8'(in_db + vol_db);
    else
      result.gain_db = 8'(in_db + vol_db + acl_pkg::SPK_OFFSET_DB);
  end

endmodule
`default_nettype wire

// *** core/acl_pkg.sv ***
// acl_pkg: constants and carriers for the amplifier control decode block
// assumes: used by acl_top and acl_chan over a 32-bit AXI4-Lite register bus
package acl_pkg;

  // register byte addresses, one 32-bit word each
  localparam logic [7:0] ADDR_INGAIN = 8'h00;
  localparam logic [7:0] ADDR_BASS   = 8'h04;
  localparam logic [7:0] ADDR_TREBLE = 8'h08;
  localparam logic [7:0] ADDR_LVOL   = 8'h0C;
  localparam logic [7:0] ADDR_RVOL   = 8'h10;
  localparam logic [7:0] ADDR_INMUX  = 8'h14;
  localparam logic [7:0] ADDR_MODE   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_LOUT   = 8'h24;
  localparam logic [7:0] ADDR_ROUT   = 8'h28;

  // reset values of the control fields
  localparam logic [2:0] RST_INGAIN = 3'h6;
  localparam logic [3:0] RST_TONE   = 4'h6;
  localparam logic [4:0] RST_VOL    = 5'h10;
  localparam logic [1:0] RST_INMUX  = 2'h0;

  // operating-mode byte bit positions
  localparam int MODE_MUTE  = 4;
  localparam int MODE_WIDEN = 2;
  localparam int MODE_SPKOFF = 1;
  localparam int MODE_SOFTPD = 0;

  // status bit positions
  localparam int ST_WIDEN  = 0;
  localparam int ST_HPMODE = 1;
  localparam int ST_PD     = 2;
  localparam int ST_LMUTE  = 3;
  localparam int ST_RMUTE  = 4;
  localparam int ST_SPKPOS = 5;

  // gain arithmetic in dB, signed
  localparam logic signed [7:0] SPK_OFFSET_DB = 8'sd6;
  localparam logic [4:0] VOL_MUTE_CODE = 5'h00;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // input source choices
  typedef enum logic [1:0] {
    ACL_SRC_SE1  = 2'b00,
    ACL_SRC_SE2  = 2'b01,
    ACL_SRC_SE3  = 2'b10,
    ACL_SRC_DIFF = 2'b11
  } acl_src_e;

  // stored control bytes, never altered by mute or shutdown
  typedef struct packed {
    logic [2:0] input_gain_code;
    logic [3:0] bass_code;
    logic [3:0] treble_code;
    logic [4:0] left_volume_code;
    logic [4:0] right_volume_code;
    logic [1:0] input_source_select;
    logic       global_mute_bit;
    logic       stereo_widen_bit;
    logic       speaker_off_bit;
    logic       soft_powerdown_bit;
  } acl_ctrl_s;

  // per-channel effective result
  typedef struct packed {
    logic              muted;
    logic signed [7:0] gain_db;
  } acl_chan_s;

endpackage

// *** core/acl_sync2.sv ***
// acl_sync2: two-flop synchroniser for pin levels
// assumes: pins are asynchronous levels; output is one level per bit
`timescale 1ns/1ps
`default_nettype none
module acl_sync2 #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RST_LEVEL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] level
);

  logic [W-1:0] meta;

  // first stage is read only by the second; reset to the idle level so no
  // false event shows up in the first cycles after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta  <= RST_LEVEL;
      level <= RST_LEVEL;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
    end
  end

endmodule
`default_nettype wire

// *** core/acl_top.sv ***
// acl_top: control decode of a stereo amplifier, reached over AXI4-Lite
// assumes: one clock, synchronous active-low reset, pins asynchronous
//
// Operation
// - widening is on when the register bit or the pin is high.
// - bass and treble are separate fields, each written by its own address.
// - left volume written only at its address, right only at its own.
// - speaker mode gain is input gain plus volume plus 6 dB.
// - headphone mode gain is input gain plus volume, no offset.
// - volume code zero mutes that channel alone.
// - global mute bit set mutes both channels.
// - clearing global mute restores the unchanged stored volumes.
// - two-bit source field picks one of three single inputs or differential.
// - headphone plug-in disables positive speaker output, enters headphone mode.
// - all control registers keep their contents through shutdown.
// - soft powerdown bit set enters software shutdown.
// - low hard powerdown pin enters hardware shutdown.
// - each write carries address and eight data bits, each acknowledged.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module acl_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // pins
  input  wire logic                stereo_widen_pin,
  input  wire logic                hard_powerdown_n,
  input  wire logic                headphone_detect,
  // effective controls
  output var  logic                widen_on,
  output var  logic                powerdown,
  output var  logic                headphone_mode,
  output var  logic                speaker_pos_en,
  output var  logic                left_muted,
  output var  logic                right_muted,
  output var  logic signed [7:0]   left_gain_db,
  output var  logic signed [7:0]   right_gain_db,
  output var  logic [3:0]          bass_code,
  output var  logic [3:0]          treble_code,
  output var  logic [1:0]          input_source_select
);

  if (ADDR_W < 6 || ADDR_W > 8)
    $error("acl_top: ADDR_W must be 6 to 8");

  acl_pkg::acl_ctrl_s ctrl;
  acl_pkg::acl_chan_s lres;
  acl_pkg::acl_chan_s rres;
  logic [2:0]         pins_s;
  logic               widen_pin_s;
  logic               hp_s;
  logic               pd_pin_n_s;

  // pins cross two flops; shutdown pin idles high, so its sync resets high
  acl_sync2 #(.W(3), .RST_LEVEL(3'h1)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({stereo_widen_pin, headphone_detect, hard_powerdown_n}),
    .level (pins_s)
  );
  assign widen_pin_s = pins_s[2];
  assign hp_s        = pins_s[1];
  assign pd_pin_n_s  = pins_s[0];

  // write channel: address and data taken in either order
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_have;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_have;
  logic              do_write;
  logic              wr_hit;

  assign do_write = aw_have && w_have && !s_axi_bvalid;

  // hold each channel once taken; ready drops while held
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_have       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (do_write)
        aw_have <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      w_have       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_have && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (do_write)
        w_have <= 1'b0;
    end
  end

  // writable words decode; anything else answers slverr
  always_comb
  begin
    case (8'(aw_addr))
      acl_pkg::ADDR_INGAIN,
      acl_pkg::ADDR_BASS,
      acl_pkg::ADDR_TREBLE,
      acl_pkg::ADDR_LVOL,
      acl_pkg::ADDR_RVOL,
      acl_pkg::ADDR_INMUX,
      acl_pkg::ADDR_MODE: wr_hit = 1'b1;
      default:            wr_hit = 1'b0;
    endcase
  end

  // write answer, one per address-data pair
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acl_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? acl_pkg::RESP_OKAY : acl_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control store: each field changes only at its own address, only lane 0
  // matters; nothing here looks at shutdown, so settings survive it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl.input_gain_code     <= acl_pkg::RST_INGAIN;
      ctrl.bass_code           <= acl_pkg::RST_TONE;
      ctrl.treble_code         <= acl_pkg::RST_TONE;
      ctrl.left_volume_code    <= acl_pkg::RST_VOL;
      ctrl.right_volume_code   <= acl_pkg::RST_VOL;
      ctrl.input_source_select <= acl_pkg::RST_INMUX;
      ctrl.global_mute_bit     <= 1'b0;
      ctrl.stereo_widen_bit    <= 1'b0;
      ctrl.speaker_off_bit     <= 1'b0;
      ctrl.soft_powerdown_bit  <= 1'b0;
    end
    else if (do_write && w_strb[0])
    begin
      case (8'(aw_addr))
        acl_pkg::ADDR_INGAIN: ctrl.input_gain_code   <= w_data[2:0];
        acl_pkg::ADDR_BASS:   ctrl.bass_code         <= w_data[3:0];
        acl_pkg::ADDR_TREBLE: ctrl.treble_code       <= w_data[3:0];
        acl_pkg::ADDR_LVOL:   ctrl.left_volume_code  <= w_data[4:0];
        acl_pkg::ADDR_RVOL:   ctrl.right_volume_code <= w_data[4:0];
        acl_pkg::ADDR_INMUX:  ctrl.input_source_select <= w_data[1:0];
        acl_pkg::ADDR_MODE:
        begin
          ctrl.global_mute_bit    <= w_data[acl_pkg::MODE_MUTE];
          ctrl.stereo_widen_bit   <= w_data[acl_pkg::MODE_WIDEN];
          ctrl.speaker_off_bit    <= w_data[acl_pkg::MODE_SPKOFF];
          ctrl.soft_powerdown_bit <= w_data[acl_pkg::MODE_SOFTPD];
        end
        default: ;
      endcase
    end
  end

  // per-channel gain and mute
  acl_chan u_left (
    .input_gain_code (ctrl.input_gain_code),
    .volume_code     (ctrl.left_volume_code),
    .global_mute     (ctrl.global_mute_bit),
    .headphone       (hp_s),
    .result          (lres)
  );

  acl_chan u_right (
    .input_gain_code (ctrl.input_gain_code),
    .volume_code     (ctrl.right_volume_code),
    .global_mute     (ctrl.global_mute_bit),
    .headphone       (hp_s),
    .result          (rres)
  );

  // effective outputs, registered; one cycle after the store or pin sync
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      widen_on            <= 1'b0;
      powerdown           <= 1'b0;
      headphone_mode      <= 1'b0;
      speaker_pos_en      <= 1'b0;
      left_muted          <= 1'b0;
      right_muted         <= 1'b0;
      left_gain_db        <= '0;
      right_gain_db       <= '0;
      bass_code           <= acl_pkg::RST_TONE;
      treble_code         <= acl_pkg::RST_TONE;
      input_source_select <= acl_pkg::RST_INMUX;
    end
    else
    begin
      widen_on            <= ctrl.stereo_widen_bit | widen_pin_s;
      powerdown           <= ctrl.soft_powerdown_bit | !pd_pin_n_s;
      headphone_mode      <= hp_s;
      speaker_pos_en      <= !hp_s && !ctrl.speaker_off_bit;
      left_muted          <= lres.muted;
      right_muted         <= rres.muted;
      left_gain_db        <= lres.gain_db;
      right_gain_db       <= rres.gain_db;
      bass_code           <= ctrl.bass_code;
      treble_code         <= ctrl.treble_code;
      input_source_select <= ctrl.input_source_select;
    end
  end

  // read channel: one cycle from address to data
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = '0;
    case (8'(s_axi_araddr))
      acl_pkg::ADDR_INGAIN: rd_word[2:0] = ctrl.input_gain_code;
      acl_pkg::ADDR_BASS:   rd_word[3:0] = ctrl.bass_code;
      acl_pkg::ADDR_TREBLE: rd_word[3:0] = ctrl.treble_code;
      acl_pkg::ADDR_LVOL:   rd_word[4:0] = ctrl.left_volume_code;
      acl_pkg::ADDR_RVOL:   rd_word[4:0] = ctrl.right_volume_code;
      acl_pkg::ADDR_INMUX:  rd_word[1:0] = ctrl.input_source_select;
      acl_pkg::ADDR_MODE:
      begin
        rd_word[acl_pkg::MODE_MUTE]   = ctrl.global_mute_bit;
        rd_word[acl_pkg::MODE_WIDEN]  = ctrl.stereo_widen_bit;
        rd_word[acl_pkg::MODE_SPKOFF] = ctrl.speaker_off_bit;
        rd_word[acl_pkg::MODE_SOFTPD] = ctrl.soft_powerdown_bit;
      end
      acl_pkg::ADDR_STATUS:
      begin
        rd_word[acl_pkg::ST_WIDEN]  = widen_on;
        rd_word[acl_pkg::ST_HPMODE] = headphone_mode;
        rd_word[acl_pkg::ST_PD]     = powerdown;
        rd_word[acl_pkg::ST_LMUTE]  = left_muted;
        rd_word[acl_pkg::ST_RMUTE]  = right_muted;
        rd_word[acl_pkg::ST_SPKPOS] = speaker_pos_en;
      end
      acl_pkg::ADDR_LOUT:   rd_word[7:0] = left_gain_db;
      acl_pkg::ADDR_ROUT:   rd_word[7:0] = right_gain_db;
      default:              rd_hit = 1'b0;
    endcase
  end

  // arready is high while idle, so one read is under way at most
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= acl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? acl_pkg::RESP_OKAY : acl_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // checks
  a_widen_or: assert property (@(posedge clk) disable iff (!rst_n)
    widen_on == $past(ctrl.stereo_widen_bit | widen_pin_s))
    else $error("widening not the or of bit and pin");
  a_widen_off: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl.stereo_widen_bit && !widen_pin_s) |=> !widen_on)
    else $error("widening stayed on");
  a_pd_or: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl.soft_powerdown_bit || !pd_pin_n_s) |=> powerdown)
    else $error("shutdown missed");
  a_pd_pin: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(hard_powerdown_n) ##1 !hard_powerdown_n [*3] |-> powerdown)
    else $error("hard shutdown pin ignored");
  a_gmute_both: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.global_mute_bit |=> left_muted && right_muted)
    else $error("global mute left a channel live");
  a_mute_keep: assert property (@(posedge clk) disable iff (!rst_n)
    !do_write |=> $stable(ctrl.left_volume_code) && $stable(ctrl.right_volume_code))
    else $error("volume changed without write");
  a_chan_indep: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl.left_volume_code == 5'h00 && ctrl.right_volume_code != 5'h00
     && !ctrl.global_mute_bit) |=> left_muted && !right_muted)
    else $error("channel mute not independent");
  a_spk_gain: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> left_gain_db == $past(u_left.in_db + u_left.vol_db
      + (hp_s ? 8'sh00 : acl_pkg::SPK_OFFSET_DB)))
    else $error("speaker offset wrong for the mode");
  a_hp_pos: assert property (@(posedge clk) disable iff (!rst_n)
    hp_s |=> headphone_mode && !speaker_pos_en)
    else $error("speaker live in headphone mode");
  a_bresp: assert property (@(posedge clk) disable iff (!rst_n)
    do_write |=> s_axi_bvalid ##0 (s_axi_bvalid [*1]))
    else $error("write not answered");

  c_write: cover property (@(posedge clk) disable iff (!rst_n) do_write && wr_hit);
  c_mute_back: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(ctrl.global_mute_bit) ##1 !left_muted);
  c_hp: cover property (@(posedge clk) disable iff (!rst_n) $rose(headphone_mode));
  c_pd: cover property (@(posedge clk) disable iff (!rst_n) $rose(powerdown));

endmodule
`default_nettype wire

// *** dv/acl_host.sv ***
// acl_host: axi4-lite master standing in for the control host
// assumes: one clock, slave answers by valid/ready, released lines are not trusted
`timescale 1ns/1ps
`default_nettype none
module acl_host (
  input  wire logic        clk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // idle bus at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // one write: address and data together, the response is the acknowledge
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] resp, output bit ok);
    int i;
    ok = 1'b0;
    resp = 2'b11;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64 && !ok; i++)
    begin
      @(posedge clk);
      // released payload is scrambled so a late sample cannot pass by luck
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready)
      begin
        resp = bresp;
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask

  // one read: data and response taken at the rvalid edge
  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp, output bit ok);
    int i;
    ok = 1'b0;
    d = '1;
    resp = 2'b11;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64 && !ok; i++)
    begin
      @(posedge clk);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready)
      begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** dv/amp_control_logic_tb.sv ***
// amp_control_logic_tb: register-level tests of the amplifier control decode
// assumes: acl_top with default address width, host model drives the bus
`timescale 1ns/1ps
`default_nettype none
module amp_control_logic_tb;
  logic               clk;
  logic               rst_n;
  logic [7:0]         awaddr, araddr;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic               widen_pin, hard_pd_n, hp_detect;
  logic               widen_on, powerdown, headphone_mode, speaker_pos_en;
  logic               left_muted, right_muted;
  logic signed [7:0]  left_gain_db, right_gain_db;
  logic [3:0]         bass_code, treble_code;
  logic [1:0]         input_source_select;
  int                 failures, comparisons, k;

  acl_host u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  acl_top u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stereo_widen_pin(widen_pin), .hard_powerdown_n(hard_pd_n),
    .headphone_detect(hp_detect), .widen_on(widen_on), .powerdown(powerdown),
    .headphone_mode(headphone_mode), .speaker_pos_en(speaker_pos_en),
    .left_muted(left_muted), .right_muted(right_muted), .left_gain_db(left_gain_db),
    .right_gain_db(right_gain_db), .bass_code(bass_code), .treble_code(treble_code),
    .input_source_select(input_source_select));

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // a lost answer counts as a failure and closes the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit ok;
    u_host.write(a, d, r, ok);
    if (!ok)
    begin
      failures++;
      summarize();
    end
    chk_word("bresp", {30'h0, er}, {30'h0, r});
    settle(2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    u_host.read(a, d, r, ok);
    if (!ok)
    begin
      failures++;
      summarize();
    end
    chk_word("rresp", {30'h0, er}, {30'h0, r});
    chk_word("rdata", ed, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // expected gain: input code*3-15, volume code*2-44 capped at +12, 6 more on speaker
  function automatic logic [31:0] gain(input int ig, input int v, input bit hp);
    int g;
    g = ig * 3 - 15 + ((v >= 28) ? 12 : v * 2 - 44) + (hp ? 0 : 6);
    return 32'(g[7:0]);
  endfunction

  localparam logic [1:0] OK = acl_pkg::RESP_OKAY;

  initial
  begin
    failures = 0;
    comparisons = 0;
    rst_n = 1'b0;
    widen_pin = 1'b0;
    hard_pd_n = 1'b1;
    hp_detect = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle(4);
    rd(acl_pkg::ADDR_INGAIN, 32'h0000_0006, OK);
    rd(acl_pkg::ADDR_STATUS, 32'h0000_0001 << acl_pkg::ST_SPKPOS, OK);
    $display("test defaults done");
    wr(acl_pkg::ADDR_BASS, 32'h0000_000C, OK);
    chk_word("bass", 32'h0000_000C, 32'(bass_code));
    chk_word("treble", 32'h0000_0006, 32'(treble_code));
    wr(acl_pkg::ADDR_TREBLE, 32'h0000_0003, OK);
    chk_word("treble", 32'h0000_0003, 32'(treble_code));
    chk_word("bass", 32'h0000_000C, 32'(bass_code));
    wr(acl_pkg::ADDR_LVOL, 32'h0000_0016, OK);
    chk_word("left gain", gain(6, 22, 0), 32'(left_gain_db[7:0]));
    chk_word("right gain", gain(6, 16, 0), 32'(right_gain_db[7:0]));
    rd(acl_pkg::ADDR_LOUT, gain(6, 22, 0), OK);
    $display("test tone and volume done");
    @(posedge clk);
    hp_detect <= 1'b1;
    settle(4);
    chk_bit("headphone mode", 1'b1, headphone_mode);
    chk_bit("speaker pos", 1'b0, speaker_pos_en);
    chk_word("left gain", gain(6, 22, 1), 32'(left_gain_db[7:0]));
    @(posedge clk);
    hp_detect <= 1'b0;
    settle(4);
    chk_bit("speaker pos", 1'b1, speaker_pos_en);
    wr(acl_pkg::ADDR_MODE, 32'h0000_0001 << acl_pkg::MODE_SPKOFF, OK);
    chk_bit("speaker pos", 1'b0, speaker_pos_en);
    $display("test headphone done");
    wr(acl_pkg::ADDR_RVOL, 32'h0000_0000, OK);
    chk_bit("right muted", 1'b1, right_muted);
    chk_bit("left muted", 1'b0, left_muted);
    wr(acl_pkg::ADDR_RVOL, 32'h0000_001F, OK);
    chk_bit("right muted", 1'b0, right_muted);
    chk_word("right gain", gain(6, 31, 0), 32'(right_gain_db[7:0]));
    wr(acl_pkg::ADDR_MODE, 32'h0000_0001 << acl_pkg::MODE_MUTE, OK);
    chk_bit("left muted", 1'b1, left_muted);
    chk_bit("right muted", 1'b1, right_muted);
    rd(acl_pkg::ADDR_LVOL, 32'h0000_0016, OK);
    wr(acl_pkg::ADDR_MODE, 32'h0000_0000, OK);
    chk_bit("left muted", 1'b0, left_muted);
    chk_word("left gain", gain(6, 22, 0), 32'(left_gain_db[7:0]));
    $display("test mute done");
    for (k = 3; k >= 0; k--)
    begin
      wr(acl_pkg::ADDR_INMUX, 32'(k), OK);
      chk_word("source", 32'(k), 32'(input_source_select));
    end
    $display("test source done");
    wr(acl_pkg::ADDR_MODE, 32'h0000_0001 << acl_pkg::MODE_WIDEN, OK);
    chk_bit("widen", 1'b1, widen_on);
    @(posedge clk);
    widen_pin <= 1'b1;
    wr(acl_pkg::ADDR_MODE, 32'h0000_0000, OK);
    settle(2);
    chk_bit("widen", 1'b1, widen_on);
    @(posedge clk);
    widen_pin <= 1'b0;
    settle(4);
    chk_bit("widen", 1'b0, widen_on);
    $display("test widen done");
    wr(acl_pkg::ADDR_MODE, 32'h0000_0001 << acl_pkg::MODE_SOFTPD, OK);
    chk_bit("powerdown", 1'b1, powerdown);
    rd(acl_pkg::ADDR_BASS, 32'h0000_000C, OK);
    chk_word("bass", 32'h0000_000C, 32'(bass_code));
    wr(acl_pkg::ADDR_MODE, 32'h0000_0000, OK);
    chk_bit("powerdown", 1'b0, powerdown);
    @(posedge clk);
    hard_pd_n <= 1'b0;
    settle(4);
    chk_bit("powerdown", 1'b1, powerdown);
    @(posedge clk);
    hard_pd_n <= 1'b1;
    settle(4);
    chk_bit("powerdown", 1'b0, powerdown);
    chk_word("treble", 32'h0000_0003, 32'(treble_code));
    $display("test shutdown done");
    wr(8'h18, 32'h0000_0005, acl_pkg::RESP_SLVERR);
    rd(8'h18, 32'h0000_0000, acl_pkg::RESP_SLVERR);
    $display("test unmapped done");
    summarize();
  end
endmodule
`default_nettype wire
